/* File: core/lab_pkg.sv */
/*
 * Shared constants and types for the logic array block: sizes, the layout
 * of the internal signal vector, product-term slots, storage modes and the
 * APB register map.
 * Assumes a single 50 MHz clock and synchronous active-high reset.
 */
package lab_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_MC     = 8;
	localparam int NUM_EXP    = 32;
	localparam int NUM_DED    = 8;
	localparam int NUM_ROUTE  = 8;
	localparam int PT_PER_MC  = 8;
	localparam int NUM_PT     = NUM_MC * PT_PER_MC;
	localparam int TERM_LIMIT = 35;
	// ----------------------------------------------------------------
	// signal vector layout
	// ----------------------------------------------------------------
	localparam int SIG_DED    = 0;
	localparam int SIG_ROUTE  = 8;
	localparam int SIG_MC     = 16;
	localparam int SIG_EXP    = 24;
	localparam int SIG_PIN    = 56;
	localparam int SIG_W      = 64;
	// ----------------------------------------------------------------
	// product term slots inside one macrocell
	// ----------------------------------------------------------------
	localparam int PT_OR0     = 0;
	localparam int PT_XOR     = 3;
	localparam int PT_PRE     = 4;
	localparam int PT_CLR     = 5;
	localparam int PT_CLK     = 6;
	localparam int PT_OE      = 7;
	localparam int NUM_OR_PT  = 3;
	// ----------------------------------------------------------------
	// storage modes and clock source
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		MODE_D      = 6'h01,
		MODE_T      = 6'h02,
		MODE_JK     = 6'h04,
		MODE_RS     = 6'h08,
		MODE_LATCH  = 6'h10,
		MODE_BYPASS = 6'h20
	} mode_type;
	localparam logic CLK_SYSTEM = 1'b0;
	localparam logic CLK_ARRAY  = 1'b1;
	// ----------------------------------------------------------------
	// default configuration
	// ----------------------------------------------------------------
	localparam logic [NUM_PT-1:0][SIG_W-1:0]  PT_MASK_RST  = '0;
	localparam logic [NUM_EXP-1:0][SIG_W-1:0] EXP_MASK_RST = '0;
	localparam logic [NUM_MC-1:0]             CLK_SRC_RST  = '0;
	localparam logic                          SINGLE_RST   = 1'b0;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  REG_SOFT_IN   = 8'h00;
	localparam logic [7:0]  REG_MC_STATE  = 8'h04;
	localparam logic [7:0]  REG_EXPANDER  = 8'h08;
	localparam logic [7:0]  SOFT_IN_RST   = 8'h00;
	localparam logic [31:0] PRDATA_RST    = 32'h0000_0000;
endpackage

/* File: core/macrocell_storage.sv */
/*
 * One macrocell: OR of three terms into an XOR, then a storage element
 * that acts as D, T, JK or RS flip-flop, as a latch, or is bypassed.
 * Assumes the product terms are formed by the enclosing array block.
 */
`timescale 1ns/100ps
module macrocell_storage
	import lab_pkg::*;
#(
	parameter mode_type MODE    = MODE_D,
	parameter logic     CLK_SRC = CLK_SYSTEM
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// product terms
	input  wire logic [NUM_OR_PT-1:0] or_terms,
	input  wire logic                 xor_term,
	input  wire logic                 preset,
	input  wire logic                 clear,
	input  wire logic                 clk_term,
	// results
	output logic q_out,
	output logic q_fb
);
	import lab_pkg::*;

	typedef struct packed {
		logic q;
		logic clk_prev;
	} mc_state_type;

	mc_state_type state_ff;
	mc_state_type nxt_state;
	logic         sum;
	logic         f;
	logic         fire;
	logic         gate;

	// ----------------------------------------------------------------
	// combinational function
	// ----------------------------------------------------------------
	assign sum  = |or_terms;
	assign f    = sum ^ xor_term;
	assign fire = (CLK_SRC == CLK_ARRAY) ?
		(clk_term & ~state_ff.clk_prev) : 1'b1;
	assign gate = (CLK_SRC == CLK_ARRAY) ? clk_term : 1'b1;

	always_comb begin
		nxt_state          = state_ff;
		nxt_state.clk_prev = clk_term;
		case (MODE)
			MODE_D: begin
				if (fire) nxt_state.q = f;
			end
			MODE_T: begin
				if (fire) nxt_state.q = state_ff.q ^ f;
			end
			MODE_JK: begin
				if (fire) nxt_state.q = (sum & ~state_ff.q) | (~xor_term & state_ff.q);
			end
			MODE_RS: begin
				if (fire && sum) nxt_state.q = 1'b1;
				else if (fire && xor_term) nxt_state.q = 1'b0;
			end
			MODE_LATCH: begin
				if (gate) nxt_state.q = f;
			end
			MODE_BYPASS: begin
				nxt_state.q = f;
			end
			default: begin
				nxt_state.q = state_ff.q;
			end
		endcase
		if (clear) nxt_state.q = 1'b0;
		else if (preset) nxt_state.q = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) state_ff <= '0;
		else state_ff <= nxt_state;
	end

	// ----------------------------------------------------------------
	// output: preset and clear act without waiting for an edge
	// ----------------------------------------------------------------
	always_comb begin
		if (clear) q_out = 1'b0;
		else if (preset) q_out = 1'b1;
		else if (MODE == MODE_BYPASS) q_out = f;
		else if (MODE == MODE_LATCH && gate) q_out = f;
		else q_out = state_ff.q;
	end
	assign q_fb = state_ff.q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_clear_async: assert property (clear |-> q_out == 1'b0)
		else $error("clear did not force output low");
	chk_preset_async: assert property ((preset && !clear) |-> q_out)
		else $error("preset did not force output high");
	chk_bypass_out: assert property (
		(MODE == MODE_BYPASS && !clear && !preset) |-> q_out == ((|or_terms) ^ xor_term))
		else $error("bypass output is not or-xor result");
	chk_d_capture: assert property (
		(MODE == MODE_D && CLK_SRC == CLK_SYSTEM && !clear && !preset)
		|=> q_fb == $past(f))
		else $error("d register missed its input");
	chk_t_toggle: assert property (
		(MODE == MODE_T && fire && !clear && !preset)
		|=> q_fb == ($past(q_fb) ^ $past(f)))
		else $error("t register toggled wrongly");
	chk_array_hold: assert property (
		(CLK_SRC == CLK_ARRAY && MODE != MODE_BYPASS && MODE != MODE_LATCH
		&& !fire && !clear && !preset) |=> $stable(q_fb))
		else $error("register moved without array clock edge");
endmodule

/* File: core/logic_array_block.sv */
/*
 * One logic array block: expander terms, macrocell array, I/O block and
 * forwarding to the global routing array, with an APB slave for a
 * software input vector and status.
 * Assumes pins and routing inputs are synchronous to clk; the pad itself
 * is resolved outside from pin_out and pin_oe.
 */
// Notes on behaviour
// - each macrocell ORs three local product terms into one XOR input.
// - the other XOR input is its own product term, for polarity, T and JK.
// - the storage element works as D, T, JK or RS flip-flop per macrocell.
// - it may instead be a transparent latch or be bypassed at q_out; q_fb still takes f through the register.
// - every register has preset and clear that force q_out without a clock edge; q_fb follows at the next edge.
// - each register is clocked by the system clock or an array product term.
// - expanders take dedicated inputs, routing, feedback, expanders and pins.
// - every expander output reaches every macrocell product term of the block and each higher-numbered expander.
// - one macrocell can use up to 35 product terms by adding expanders.
// - expanders may also form preset, clear, clock and enable terms.
// - expanders may feed other expanders for multilevel logic.
// - each pad has a three-state driver fed by a macrocell and a term.
// - all signals made inside the block reach every product term; an expander sees only lower-numbered expanders.
// - macrocell outputs and pin feedback go out to the routing array.
// - a single-block device uses one global bus and no routing array.
// - pin feedback is usable apart from the macrocell register.
`timescale 1ns/100ps
module logic_array_block
	import lab_pkg::*;
#(
	parameter logic [NUM_PT-1:0][SIG_W-1:0]  PT_TRUE    = PT_MASK_RST,
	parameter logic [NUM_PT-1:0][SIG_W-1:0]  PT_COMP    = PT_MASK_RST,
	parameter logic [NUM_EXP-1:0][SIG_W-1:0] EXP_TRUE   = EXP_MASK_RST,
	parameter logic [NUM_EXP-1:0][SIG_W-1:0] EXP_COMP   = EXP_MASK_RST,
	parameter mode_type                      MC_MODE [NUM_MC] = '{default: MODE_D},
	parameter logic [NUM_MC-1:0]             MC_CLK_SRC = CLK_SRC_RST,
	parameter logic                          SINGLE     = SINGLE_RST
) (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// apb slave
	input  wire logic [lab_pkg::ADDR_W-1:0]     paddr,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	// dedicated inputs and routing array
	input  wire logic [lab_pkg::NUM_DED-1:0]    ded_in,
	input  wire logic [lab_pkg::NUM_ROUTE-1:0]  route_in,
	output logic      [2*lab_pkg::NUM_MC-1:0]   route_out,
	// i/o pads
	input  wire logic [lab_pkg::NUM_MC-1:0]     pin_in,
	output logic      [lab_pkg::NUM_MC-1:0]     pin_out,
	output logic      [lab_pkg::NUM_MC-1:0]     pin_oe
);
	import lab_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_DED-1:0] soft_in;
		logic [31:0]        prdata;
		logic               pslverr;
	} lab_state_type;

	lab_state_type        state_ff;
	lab_state_type        nxt_state;
	logic [SIG_W-1:0]     sig;
	logic [NUM_DED-1:0]   ded_bus;
	logic [NUM_ROUTE-1:0] route_bus;
	logic [NUM_EXP-1:0]   exp_out;
	logic [NUM_PT-1:0]    pt;
	logic [NUM_MC-1:0]    mc_out;
	logic [NUM_MC-1:0]    mc_fb;
	logic                 setup;
	logic                 access;
	logic                 mapped;

	// and of true literals and complemented literals; an empty term is true
	function automatic logic pterm(
		input logic [SIG_W-1:0] s,
		input logic [SIG_W-1:0] mt,
		input logic [SIG_W-1:0] mc
	);
		pterm = &((s | ~mt) & (~s | ~mc));
	endfunction

	// ----------------------------------------------------------------
	// global feedback vector
	// ----------------------------------------------------------------
	assign ded_bus   = ded_in | state_ff.soft_in;
	// single-block parts have no routing array to listen to
	assign route_bus = SINGLE ? '0 : route_in;
	always_comb begin
		sig = '0;
		sig[SIG_DED   +: NUM_DED]   = ded_bus;
		sig[SIG_ROUTE +: NUM_ROUTE] = route_bus;
		sig[SIG_MC    +: NUM_MC]    = mc_fb;
		sig[SIG_EXP   +: NUM_EXP]   = exp_out;
		sig[SIG_PIN   +: NUM_MC]    = pin_in;
	end

	// ----------------------------------------------------------------
	// expander terms
	// ----------------------------------------------------------------
	// an expander sees only lower-numbered expanders, which keeps the
	// array free of combinational loops
	generate
		for (genvar k = 0; k < NUM_EXP; k++) begin : g_exp
			logic [SIG_W-1:0] keep;
			always_comb begin
				keep = '1;
				for (int b = k; b < NUM_EXP; b++) begin
					keep[SIG_EXP + b] = 1'b0;
				end
			end
			assign exp_out[k] = ~pterm(sig, EXP_TRUE[k] & keep, EXP_COMP[k] & keep);
		end
	endgenerate

	// ----------------------------------------------------------------
	// macrocell array
	// ----------------------------------------------------------------
	generate
		for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
			for (genvar t = 0; t < PT_PER_MC; t++) begin : g_pt
				assign pt[m*PT_PER_MC + t] = pterm(sig,
					PT_TRUE[m*PT_PER_MC + t], PT_COMP[m*PT_PER_MC + t]);
			end
			macrocell_storage #(
				.MODE    (MC_MODE[m]),
				.CLK_SRC (MC_CLK_SRC[m])
			) u_mc (
				.clk      (clk),
				.rst      (rst),
				.or_terms (pt[m*PT_PER_MC + PT_OR0 +: NUM_OR_PT]),
				.xor_term (pt[m*PT_PER_MC + PT_XOR]),
				.preset   (pt[m*PT_PER_MC + PT_PRE]),
				.clear    (pt[m*PT_PER_MC + PT_CLR]),
				.clk_term (pt[m*PT_PER_MC + PT_CLK]),
				.q_out    (mc_out[m]),
				.q_fb     (mc_fb[m])
			);
			assign pin_out[m] = mc_out[m];
			assign pin_oe[m]  = pt[m*PT_PER_MC + PT_OE];
		end
	endgenerate

	// ----------------------------------------------------------------
	// routing array forwarding
	// ----------------------------------------------------------------
	assign route_out = SINGLE ? '0 : {pin_in, mc_out};

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign mapped = (paddr == REG_SOFT_IN) || (paddr == REG_MC_STATE)
		|| (paddr == REG_EXPANDER);

	always_comb begin
		nxt_state = state_ff;
		if (setup) begin
			nxt_state.pslverr = ~mapped;
			nxt_state.prdata  = '0;
			if (!pwrite) begin
				case (paddr)
					REG_SOFT_IN: begin
						nxt_state.prdata[NUM_DED-1:0] = state_ff.soft_in;
					end
					REG_MC_STATE: begin
						nxt_state.prdata[2*NUM_MC-1:0] = {pin_in, mc_out};
					end
					REG_EXPANDER: begin
						nxt_state.prdata[NUM_EXP-1:0] = exp_out;
					end
					default: begin
						nxt_state.prdata = '0;
					end
				endcase
			end
		end
		if (access && pwrite && paddr == REG_SOFT_IN) begin
			nxt_state.soft_in = pwdata[NUM_DED-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff.soft_in <= SOFT_IN_RST;
			state_ff.prdata  <= PRDATA_RST;
			state_ff.pslverr <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = state_ff.prdata;
	assign pslverr = access & state_ff.pslverr;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_write_soft;
		setup && pwrite && paddr == REG_SOFT_IN ##1 access && pwrite;
	endsequence

	sequence s_read_bad;
		setup && !mapped ##1 access;
	endsequence

	sequence s_write_other;
		setup && pwrite && paddr != REG_SOFT_IN ##1 access && pwrite;
	endsequence

	sequence s_read_soft;
		setup && !pwrite && paddr == REG_SOFT_IN;
	endsequence

	sequence s_read_exp;
		setup && !pwrite && paddr == REG_EXPANDER;
	endsequence

	// ----------------------------------------------------------------
	// checks: pads, feedback and routing
	// ----------------------------------------------------------------
	chk_pad_data: assert property (pin_out == mc_out)
		else $error("pad data differs from macrocell output");

	chk_route_fwd: assert property (
		!SINGLE |-> route_out == {pin_in, mc_out})
		else $error("routing array forwarding wrong");

	chk_single_bus: assert property (
		SINGLE |-> route_out == '0 && route_bus == '0)
		else $error("single block still uses routing array");

	chk_single_in: assert property (
		SINGLE |-> sig[SIG_ROUTE +: NUM_ROUTE] == '0)
		else $error("single block listens to routing inputs");

	chk_feedback_map: assert property (
		sig[SIG_MC +: NUM_MC] == mc_fb && sig[SIG_EXP +: NUM_EXP] == exp_out)
		else $error("internal feedback missing from vector");

	chk_pin_feedback: assert property (
		sig[SIG_PIN +: NUM_MC] == pin_in)
		else $error("pin feedback missing from vector");

	chk_ded_merge: assert property (
		(ded_bus & ded_in) == ded_in)
		else $error("dedicated input lost on the bus");

	// per macrocell: enable term, feedback and forwarded bits
	generate
		for (genvar m = 0; m < NUM_MC; m++) begin : g_chk
			chk_oe_term: assert property (
				pin_oe[m] == pt[m*PT_PER_MC + PT_OE])
				else $error("pad enable differs from its product term");

			chk_fb_bit: assert property (
				sig[SIG_MC + m] == mc_fb[m] && sig[SIG_PIN + m] == pin_in[m])
				else $error("feedback bit missing from vector");

			chk_fwd_bit: assert property (
				!SINGLE |-> route_out[m] == mc_out[m]
				&& route_out[NUM_MC + m] == pin_in[m])
				else $error("forwarded bit differs from its source");
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks: register bus
	// ----------------------------------------------------------------
	chk_soft_write: assert property (
		s_write_soft |=> ded_bus == ($past(pwdata[NUM_DED-1:0]) | ded_in))
		else $error("software input not applied to dedicated bus");

	chk_bad_addr: assert property (s_read_bad |-> pslverr && prdata == '0)
		else $error("unmapped address not refused");

	chk_status_read: assert property (
		(setup && !pwrite && paddr == REG_MC_STATE)
		|=> prdata[2*NUM_MC-1:0] == $past({pin_in, mc_out}))
		else $error("status read does not match state");

	chk_soft_read: assert property (
		s_read_soft |=> prdata[NUM_DED-1:0] == $past(state_ff.soft_in))
		else $error("software input read back wrongly");

	chk_exp_read: assert property (
		s_read_exp |=> prdata[NUM_EXP-1:0] == $past(exp_out))
		else $error("expander outputs read back wrongly");

	chk_write_zero: assert property ((setup && pwrite) |=> prdata == '0)
		else $error("write cycle shows read data");

	chk_write_ignored: assert property (s_write_other |=> $stable(state_ff.soft_in))
		else $error("read-only register took a write");

	chk_setup_err: assert property (setup |=> state_ff.pslverr == !$past(mapped))
		else $error("error flag not loaded in setup");

	chk_err_idle: assert property (!access |-> !pslverr)
		else $error("slave error outside access phase");

	chk_prdata_hold: assert property (!setup |=> $stable(prdata))
		else $error("read data moved outside setup");
endmodule

/* File: verification/io_pad_model.sv */
/*
 * Pad partner: resolves each i/o pad from the block's driver and an
 * external driver; a pad that nobody drives shows a changing pattern.
 * Assumes the bench never enables an external driver on a driven pad.
 */
`timescale 1ns/100ps
module io_pad_model (
	// clock
	input  wire logic       clk,
	// block side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// external side
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_in
);
	logic [7:0] float_ff = 8'h5a;

	// released pad never holds its last value
	always @(posedge clk) float_ff <= ~float_ff;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i] && ext_en[i]) pin_in[i] = 1'bx;
			else if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (ext_en[i]) pin_in[i] = ext_val[i];
			else pin_in[i] = float_ff[i];
		end
	end
endmodule

/* File: verification/logic_array_block_tb.sv */
/*
 * Self-checking bench for the logic array block: a reference model of the
 * configured macrocells and expanders, random inputs and APB traffic.
 * Assumes the configuration built below and the zero-wait APB slave.
 */
`timescale 1ns/100ps
module logic_array_block_tb;
	import lab_pkg::*;
	// ----------------------------------------------------------------
	// configuration and expectations
	// ----------------------------------------------------------------
	function automatic logic [NUM_PT-1:0][SIG_W-1:0] pt_cfg(input bit comp);
		logic [NUM_PT-1:0][SIG_W-1:0] m;
		int b;
		m = '0;
		for (int i = 0; i < NUM_MC; i++) begin
			b = i * PT_PER_MC;
			m[b+PT_OR0+2][SIG_DED] = 1'b1;
			if (!comp) m[b+PT_OR0][SIG_DED+i] = 1'b1;
			if (i != 5) m[b+PT_OR0+1][SIG_DED] = 1'b1;
			else m[b+PT_OR0+1][SIG_EXP+1] = !comp;
			if (i == 2 || i == 3) m[b+PT_XOR][SIG_DED] = !comp;
			else if (i != 4) m[b+PT_XOR][SIG_DED] = 1'b1;
			m[b+PT_PRE][SIG_PIN+7] = (i == 7) && !comp;
			m[b+PT_CLR][SIG_PIN+6] = (i == 7) && !comp;
			m[b+PT_PRE][SIG_DED] = (i != 7);
			m[b+PT_CLR][SIG_DED] = (i != 7);
			if (i == 6) m[b+PT_CLK][SIG_ROUTE+7] = !comp;
			if (i < 6) m[b+PT_OE][SIG_ROUTE+i] = !comp;
			else m[b+PT_OE][SIG_DED] = 1'b1;
		end
		return m;
	endfunction

	function automatic logic [NUM_EXP-1:0][SIG_W-1:0] exp_cfg(input bit comp);
		logic [NUM_EXP-1:0][SIG_W-1:0] e;
		e = '0;
		if (!comp) begin
			e[0][SIG_PIN] = 1'b1;
			e[1][SIG_EXP] = 1'b1;
			e[1][SIG_ROUTE+1] = 1'b1;
			e[2][SIG_MC] = 1'b1;
		end
		return e;
	endfunction

	localparam mode_type MODES [NUM_MC] = '{MODE_D, MODE_T, MODE_JK, MODE_RS,
		MODE_LATCH, MODE_BYPASS, MODE_D, MODE_D};

	function automatic logic [2:0] exp_f(input logic [7:0] p, r, q);
		return {~q[0], ~(~p[0] & r[1]), ~p[0]};
	endfunction

	function automatic logic [7:0] out_f(input logic [7:0] d, p, q, input logic e1);
		out_f = q;
		out_f[4] = ~d[4];
		out_f[5] = d[5] | e1;
		if (p[6]) out_f[7] = 1'b0;
		else if (p[7]) out_f[7] = 1'b1;
	endfunction

	function automatic logic [7:0] next_f(input logic [7:0] d, p, r, q,
		input logic e1, pv);
		next_f[0] = d[0];
		next_f[1] = q[1] ^ d[1];
		next_f[2] = (d[2] & ~q[2]) | (~d[0] & q[2]);
		next_f[3] = d[3] | (~d[0] & q[3]);
		next_f[4] = ~d[4];
		next_f[5] = d[5] | e1;
		next_f[6] = (r[7] & ~pv) ? d[6] : q[6];
		next_f[7] = p[6] ? 1'b0 : (p[7] | d[7]);
	endfunction
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic        clk = 1'b0;
	logic        rst;
	logic [7:0]  paddr;
	logic        psel, penable, pwrite;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr;
	logic [7:0]  ded_in, route_in, pin_in, pin_out, pin_oe, ext_en, ext_val;
	logic [15:0] route_out, route_out2;
	logic [7:0]  q_m, soft_m, dd, mo;
	logic [2:0]  ex;
	logic        pv_m;
	int          num_errors = 0;
	int          n_compared = 0;
	int          seed = 32'h505a93ae;
	logic [7:0]  addr_tab [4] = '{REG_SOFT_IN, REG_MC_STATE, REG_EXPANDER, 8'h0c};

	always #10 clk = ~clk;

	logic_array_block #(.PT_TRUE(pt_cfg(0)), .PT_COMP(pt_cfg(1)), .EXP_TRUE(exp_cfg(0)),
		.EXP_COMP(exp_cfg(1)), .MC_MODE(MODES), .MC_CLK_SRC(8'h40)) DUT (
		.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ded_in(ded_in), .route_in(route_in), .route_out(route_out),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

	logic_array_block #(.PT_TRUE(pt_cfg(0)), .PT_COMP(pt_cfg(1)), .EXP_TRUE(exp_cfg(0)),
		.EXP_COMP(exp_cfg(1)), .MC_MODE(MODES), .MC_CLK_SRC(8'h40), .SINGLE(1'b1)) DUT2 (
		.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.ded_in(ded_in), .route_in(route_in), .route_out(route_out2),
		.pin_in(pin_in), .pin_out(), .pin_oe());

	io_pad_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));
	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, expected, input string what);
		n_compared++;
		if (seen !== expected) begin
			num_errors++;
			$display("Error %0t: %s seen %h expected %h", $time, what, seen, expected);
		end
	endtask

	task conclude;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	always_comb begin
		dd = ded_in | soft_m;
		ex = exp_f(pin_in, route_in, q_m);
		mo = out_f(dd, pin_in, q_m, ex[1]);
	end

	always @(posedge clk) begin
		if (rst) begin
			q_m <= '0;
			pv_m <= 1'b0;
			soft_m <= SOFT_IN_RST;
		end else begin
			check(pin_out, mo, "macrocell outputs");
			check(pin_oe, {2'b00, route_in[5:0]}, "pad enables");
			check(route_out, {pin_in, mo}, "routed outputs");
			check(route_out2, 16'h0000, "single block routing");
			q_m <= next_f(dd, pin_in, route_in, q_m, ex[1], pv_m);
			pv_m <= route_in[7];
		end
	end
	// ----------------------------------------------------------------
	// apb master
	// ----------------------------------------------------------------
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		logic [31:0] er;
		logic        ee;
		int          n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		ee = !(a inside {REG_SOFT_IN, REG_MC_STATE, REG_EXPANDER});
		er = (ee || wr) ? 32'h0 : (a == REG_SOFT_IN) ? {24'h0, soft_m} :
			(a == REG_MC_STATE) ? {16'h0, pin_in, mo} : {29'h0, ex};
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check({31'h0, pready}, 32'h1, "apb answer");
		check(prdata, er, "read data");
		check({31'h0, pslverr}, {31'h0, ee}, "slave error");
		if (wr && !ee && a == REG_SOFT_IN) soft_m <= wd[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] r;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ded_in, route_in, ext_val} = '0;
		ext_en = 8'hff;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(REG_SOFT_IN, 1'b0, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			apb(k[0] ? REG_SOFT_IN : addr_tab[k / 2 + 1], k < 5 && k != 1,
				32'hffff_ff5a);
		end
		$display("test register map done");
		for (int k = 0; k < 600; k++) begin
			@(posedge clk);
			r = $random(seed);
			route_in <= r[7:0];
			ext_en <= {r[9:8], ~r[5:0]};
			ext_val <= r[17:10];
			ded_in <= r[25:18];
			if (r[28:26] == 3'h0) apb(addr_tab[r[31:30]], r[29], $random(seed));
		end
		$display("test random traffic done");
		conclude;
	end

	initial begin
		#1000000;
		num_errors++;
		$display("Error %0t: watchdog expired", $time);
		conclude;
	end
endmodule
